/* pkg/fcr_map.svh */
// Offsets, field positions, reset values and timing counts for the
// function control register bank; assumes a 32-bit byte-addressed bus.
`ifndef FCR_MAP_SVH
`define FCR_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define FCR_OFS_FCTRL0 4'h0
`define FCR_OFS_AUTOCAL0 4'h4
`define FCR_OFS_AUTOCAL1 4'h8
`define FCR_OFS_AUTOCAL2 4'hC
`define FCR_RESET_VALUE 32'h0000_0000

// ----------------------------------------
// control zero fields
// ----------------------------------------
`define FCR_FILT_LSB 20
`define FCR_FILT_MSB 25
`define FCR_KEYWIPE_BIT 8
`define FCR_RANGE_MSB 2
`define FCR_RANGE_LSB 0

// ----------------------------------------
// autocal fields
// ----------------------------------------
`define FCR_TRIM_MSB 31
`define FCR_TRIM_LSB 23
`define FCR_GAIN_MSB 19
`define FCR_GAIN_LSB 8
`define FCR_ATOMIC_BIT 4
`define FCR_INVERT_BIT 3
`define FCR_LOAD_BIT 2
`define FCR_EN_BIT 1
`define FCR_SEL_BIT 0
`define FCR_INIT_MSB 8
`define FCR_INIT_LSB 0
`define FCR_DIV_MSB 20
`define FCR_DIV_LSB 8
`define FCR_RUN_MSB 7
`define FCR_RUN_LSB 0

// ----------------------------------------
// timing
// ----------------------------------------
`define FCR_CLK_HZ 100000000
`define FCR_MS_PER_S 1000
`define FCR_MS_CYCLES (`FCR_CLK_HZ / `FCR_MS_PER_S)
`define FCR_REF_HZ 32768

`endif

/* pkg/fcr_pkg.sv */
// Types shared by the function control register bank.
// Assumes fcr_map.svh holds all numeric constants.
package fcr_pkg;

	// calibration sequencer, gray coded along idle -> run -> finish
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_RUN = 2'b01,
		CAL_FINISH = 2'b11
	} cal_state_type;

endpackage : fcr_pkg

/* rtl/fcr_cmd_bit.sv */
// Self-clearing command bit: set by a write of 1, cleared by done.
// Assumes done is a one-cycle pulse from the operation it started.
`timescale 1ns/100ps
module fcr_cmd_bit (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic set_req,
	input wire logic done,
	output logic busy,
	output logic start
);
	import fcr_pkg::*;

	logic busy_reg;
	logic busy_next;
	logic start_reg;
	logic start_next;

	// set wins over done so a back-to-back command is never lost
	always_comb begin
		busy_next = busy_reg;
		start_next = 1'b0;
		if (set_req) begin
			busy_next = 1'b1;
			start_next = ~busy_reg | done;
		end else if (done) begin
			busy_next = 1'b0;
		end
	end

	// register only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busy_reg <= 1'b0;
			start_reg <= 1'b0;
		end else if (clk_en) begin
			busy_reg <= busy_next;
			start_reg <= start_next;
		end
	end

	assign busy = busy_reg;
	assign start = start_reg;

endmodule : fcr_cmd_bit

/* rtl/function_control_registers.sv */
// Function control register bank: filter enables, crystal range, key wipe
// command and internal primary oscillator calibration.
// Assumes a classic Wishbone master on the system clock and a measurement
// block that counts oscillator cycles per 32768 Hz reference period.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "fcr_map.svh"
module function_control_registers #(
	parameter int MS_CYCLES = `FCR_MS_CYCLES,
	parameter logic [8:0] DEFAULT_TRIM = 9'h100
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic bus0_clk_line_filter_on,
	output logic bus0_dat_line_filter_on,
	output logic bus1_clk_line_filter_on,
	output logic bus1_dat_line_filter_on,
	output logic bus2_clk_line_filter_on,
	output logic bus2_dat_line_filter_on,
	output logic [2:0] crystal_range,
	output logic system_key_wipe_go,
	input wire logic system_key_wipe_done,
	input wire logic ref_tick,
	input wire logic [12:0] osc_cycle_count,
	output logic [8:0] osc_trim,
	output logic cal_active
);
	import fcr_pkg::*;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic ack_reg;
	logic ack_next;
	logic [31:0] rdat_reg;
	logic [31:0] rdat_next;
	logic req;
	logic wr;
	logic mapped;
	logic [31:0] wmask;
	logic [31:0] rd_word;
	logic [3:0] ofs;

	// one request per ack; ack drops the cycle after it rose
	assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wr = req & wb_we_i;
	assign mapped = (wb_adr_i[31:4] == 28'h0000000);
	assign ofs = {wb_adr_i[3:2], 2'b00};
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// ----------------------------------------
	// field storage
	// ----------------------------------------
	logic [5:0] filt_reg;
	logic [5:0] filt_next;
	logic [2:0] range_reg;
	logic [2:0] range_next;
	logic [11:0] gain_reg;
	logic [11:0] gain_next;
	logic en_reg;
	logic en_next;
	logic sel_reg;
	logic sel_next;
	logic [8:0] init_reg;
	logic [8:0] init_next;
	logic [12:0] div_reg;
	logic [12:0] div_next;
	logic [7:0] runtime_reg;
	logic [7:0] runtime_next;
	logic [31:0] wd0;
	logic [31:0] wd1;
	logic [31:0] wd2;
	logic [31:0] wd3;
	logic wr0;
	logic wr1;
	logic wr2;
	logic wr3;

	assign wr0 = wr & mapped & (ofs == `FCR_OFS_FCTRL0);
	assign wr1 = wr & mapped & (ofs == `FCR_OFS_AUTOCAL0);
	assign wr2 = wr & mapped & (ofs == `FCR_OFS_AUTOCAL1);
	assign wr3 = wr & mapped & (ofs == `FCR_OFS_AUTOCAL2);

	// byte-lane merge of write data over the current word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [31:0] m);
		merge = (old & ~m) | (dat & m);
	endfunction : merge

	// ----------------------------------------
	// command bits
	// ----------------------------------------
	logic wipe_busy;
	logic wipe_start;
	logic atomic_busy;
	logic atomic_start;
	logic load_busy;
	logic load_start;
	logic set_wipe;
	logic set_atomic;
	logic set_load;
	logic cal_done;

	// only a written 1 in an enabled lane starts a command
	assign set_wipe = wr0 & wmask[`FCR_KEYWIPE_BIT] & wb_dat_i[`FCR_KEYWIPE_BIT];
	assign set_atomic = wr1 & wmask[`FCR_ATOMIC_BIT] & wb_dat_i[`FCR_ATOMIC_BIT];
	assign set_load = wr1 & wmask[`FCR_LOAD_BIT] & wb_dat_i[`FCR_LOAD_BIT];

	fcr_cmd_bit u_wipe (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.set_req(set_wipe),
		.done(system_key_wipe_done),
		.busy(wipe_busy),
		.start(wipe_start)
	);

	fcr_cmd_bit u_atomic (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.set_req(set_atomic),
		.done(cal_done),
		.busy(atomic_busy),
		.start(atomic_start)
	);

	// load finishes the cycle after it starts, so done is the start pulse
	fcr_cmd_bit u_load (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.set_req(set_load),
		.done(load_start),
		.busy(load_busy),
		.start(load_start)
	);

	// ----------------------------------------
	// writable fields
	// ----------------------------------------
	always_comb begin
		wd0 = merge({6'h00, filt_reg, 17'h00000, range_reg}, wb_dat_i, wmask);
		wd1 = merge({12'h000, gain_reg, 6'h00, en_reg, sel_reg}, wb_dat_i, wmask);
		wd2 = merge({23'h000000, init_reg}, wb_dat_i, wmask);
		wd3 = merge({11'h000, div_reg, runtime_reg}, wb_dat_i, wmask);
		filt_next = wr0 ? wd0[`FCR_FILT_MSB:`FCR_FILT_LSB] : filt_reg;
		range_next = wr0 ? wd0[`FCR_RANGE_MSB:`FCR_RANGE_LSB] : range_reg;
		gain_next = wr1 ? wd1[`FCR_GAIN_MSB:`FCR_GAIN_LSB] : gain_reg;
		en_next = wr1 ? wd1[`FCR_EN_BIT] : en_reg;
		sel_next = wr1 ? wd1[`FCR_SEL_BIT] : sel_reg;
		init_next = wr2 ? wd2[`FCR_INIT_MSB:`FCR_INIT_LSB] : init_reg;
		div_next = wr3 ? wd3[`FCR_DIV_MSB:`FCR_DIV_LSB] : div_reg;
		runtime_next = wr3 ? wd3[`FCR_RUN_MSB:`FCR_RUN_LSB] : runtime_reg;
	end

	// register only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			filt_reg <= 6'h00;
			range_reg <= 3'h0;
			gain_reg <= 12'h000;
			en_reg <= 1'b0;
			sel_reg <= 1'b0;
			init_reg <= 9'h000;
			div_reg <= 13'h0000;
			runtime_reg <= 8'h00;
		end else if (clk_en) begin
			filt_reg <= filt_next;
			range_reg <= range_next;
			gain_reg <= gain_next;
			en_reg <= en_next;
			sel_reg <= sel_next;
			init_reg <= init_next;
			div_reg <= div_next;
			runtime_reg <= runtime_next;
		end
	end

	// ----------------------------------------
	// calibration sequencer
	// ----------------------------------------
	cal_state_type state_reg;
	cal_state_type state_next;
	logic [$clog2(MS_CYCLES)-1:0] ms_cnt_reg;
	logic [$clog2(MS_CYCLES)-1:0] ms_cnt_next;
	logic [7:0] ms_left_reg;
	logic [7:0] ms_left_next;
	logic ms_wrap;

	assign ms_wrap = (ms_cnt_reg == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
	assign cal_done = (state_reg == CAL_FINISH);

	// a zero runtime ends at once rather than running forever
	always_comb begin
		state_next = state_reg;
		ms_cnt_next = ms_cnt_reg;
		ms_left_next = ms_left_reg;
		case (state_reg)
			CAL_IDLE: begin
				if (atomic_start) begin
					ms_cnt_next = '0;
					ms_left_next = runtime_reg;
					state_next = (runtime_reg == 8'h00) ? CAL_FINISH : CAL_RUN;
				end
			end
			CAL_RUN: begin
				ms_cnt_next = ms_wrap ? '0 : ms_cnt_reg + 1'b1;
				if (ms_wrap) begin
					ms_left_next = ms_left_reg - 8'h01;
					if (ms_left_reg == 8'h01) begin
						state_next = CAL_FINISH;
					end
				end
			end
			CAL_FINISH: begin
				state_next = CAL_IDLE;
			end
			default: begin
				state_next = CAL_IDLE;
			end
		endcase
	end

	// register only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= CAL_IDLE;
			ms_cnt_reg <= '0;
			ms_left_reg <= 8'h00;
		end else if (clk_en) begin
			state_reg <= state_next;
			ms_cnt_reg <= ms_cnt_next;
			ms_left_reg <= ms_left_next;
		end
	end

	// ----------------------------------------
	// trim adaptation
	// ----------------------------------------
	logic [8:0] trim_reg;
	logic [8:0] trim_next;
	logic invert_reg;
	logic invert_next;
	logic dir_up_reg;
	logic dir_up_next;
	logic adapting;
	logic [12:0] target;
	logic [9:0] step;
	logic [9:0] sum;

	assign adapting = (state_reg == CAL_RUN) | en_reg;
	assign target = (div_reg == 13'h0000) ? 13'h0001 : div_reg;
	// larger gain, larger trim step; high gain bits keep steps coarse
	assign step = {6'h00, gain_reg[11:8]} + 10'h001;

	// load overrides adaptation in the same cycle
	always_comb begin
		trim_next = trim_reg;
		invert_next = invert_reg;
		dir_up_next = dir_up_reg;
		sum = 10'h000;
		if (load_start) begin
			trim_next = init_reg;
		end else if (adapting & ref_tick & (osc_cycle_count != target)) begin
			// slow oscillator: raise trim, saturating at both ends
			if (osc_cycle_count < target) begin
				sum = {1'b0, trim_reg} + step;
				trim_next = sum[9] ? 9'h1FF : sum[8:0];
				dir_up_next = 1'b1;
			end else begin
				sum = {1'b0, trim_reg} - step;
				trim_next = sum[9] ? 9'h000 : sum[8:0];
				dir_up_next = 1'b0;
			end
			invert_next = (dir_up_next != dir_up_reg);
		end
	end

	// register only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trim_reg <= 9'h000;
			invert_reg <= 1'b0;
			dir_up_reg <= 1'b0;
		end else if (clk_en) begin
			trim_reg <= trim_next;
			invert_reg <= invert_next;
			dir_up_reg <= dir_up_next;
		end
	end

	// ----------------------------------------
	// read mux and answer
	// ----------------------------------------
	always_comb begin
		rd_word = 32'h0000_0000;
		case (ofs)
			`FCR_OFS_FCTRL0: begin
				rd_word = {6'h00, filt_reg, 11'h000, wipe_busy, 5'h00, range_reg};
			end
			`FCR_OFS_AUTOCAL0: begin
				rd_word = {trim_reg, 3'h0, gain_reg, 3'h0, atomic_busy, invert_reg,
					load_busy, en_reg, sel_reg};
			end
			`FCR_OFS_AUTOCAL1: begin
				rd_word = {23'h000000, init_reg};
			end
			`FCR_OFS_AUTOCAL2: begin
				rd_word = {11'h000, div_reg, runtime_reg};
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
		// unmapped addresses still ack, reading zero
		if (!mapped) begin
			rd_word = 32'h0000_0000;
		end
		ack_next = req;
		rdat_next = (req & ~wb_we_i) ? rd_word : rdat_reg;
	end

	// register only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_reg <= 1'b0;
			rdat_reg <= `FCR_RESET_VALUE;
		end else if (clk_en) begin
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
		end
	end

	// ----------------------------------------
	// output stage
	// ----------------------------------------
	logic [8:0] otrim_reg;
	logic [8:0] otrim_next;

	// oscillator sees zero trim from reset, then default trim until software selects calibrated trim
	always_comb begin
		otrim_next = sel_reg ? trim_reg : DEFAULT_TRIM;
	end

	// register only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			otrim_reg <= 9'h000;
		end else if (clk_en) begin
			otrim_reg <= otrim_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
	assign {bus2_clk_line_filter_on, bus2_dat_line_filter_on, bus1_clk_line_filter_on,
		bus1_dat_line_filter_on, bus0_clk_line_filter_on, bus0_dat_line_filter_on} = filt_reg;
	assign crystal_range = range_reg;
	assign system_key_wipe_go = wipe_busy;
	assign osc_trim = otrim_reg;
	assign cal_active = atomic_busy;

endmodule : function_control_registers

/* tb/function_control_registers_checker.sv */
// Checker for the function control register bank, bound to its ports.
// Assumes a single clock domain and a master that drops stb after ack.
`timescale 1ns/100ps
module fcr_checker #(
	parameter int MS_CYCLES = 100000,
	parameter logic [8:0] DEFAULT_TRIM = 9'h100
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic bus0_clk_line_filter_on,
	input wire logic bus0_dat_line_filter_on,
	input wire logic bus1_clk_line_filter_on,
	input wire logic bus1_dat_line_filter_on,
	input wire logic bus2_clk_line_filter_on,
	input wire logic bus2_dat_line_filter_on,
	input wire logic [2:0] crystal_range,
	input wire logic system_key_wipe_go,
	input wire logic system_key_wipe_done,
	input wire logic [8:0] osc_trim,
	input wire logic cal_active
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// a request is taken only while ack is low, so a held stb is not a second one
	wire taken = wb_cyc_i && wb_stb_i && clk_en && !wb_ack_o;
	wire wr0 = taken && wb_we_i && wb_adr_i == 32'h0;
	wire wr4 = taken && wb_we_i && wb_adr_i == 32'h4;
	wire [5:0] filt = {bus2_clk_line_filter_on, bus2_dat_line_filter_on,
		bus1_clk_line_filter_on, bus1_dat_line_filter_on,
		bus0_clk_line_filter_on, bus0_dat_line_filter_on};
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_ACK_ONE: assert property (taken |=> wb_ack_o)
		else $error("ack missing after request");
	AST_ACK_DROP: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	AST_FILT_WR: assert property (wr0 && wb_sel_i[3:2] == 2'h3
		|=> filt == $past(wb_dat_i[25:20]))
		else $error("filter enables differ from written data");
	AST_RANGE_WR: assert property (wr0 && wb_sel_i[0]
		|=> crystal_range == $past(wb_dat_i[2:0]))
		else $error("crystal range differs from written data");
	AST_WIPE_SET: assert property (wr0 && wb_sel_i[1] && wb_dat_i[8]
		|=> ##[0:1] system_key_wipe_go)
		else $error("wipe command not started");
	AST_WIPE_HOLD: assert property (system_key_wipe_go
		&& !system_key_wipe_done && clk_en |=> system_key_wipe_go)
		else $error("wipe command dropped before done");
	AST_WIPE_CLR: assert property (system_key_wipe_go && system_key_wipe_done
		&& clk_en && !wb_stb_i |=> !system_key_wipe_go)
		else $error("wipe command not cleared by done");
	AST_CAL_SET: assert property (wr4 && wb_sel_i[0] && wb_dat_i[4]
		|=> ##[0:1] cal_active)
		else $error("timed calibration not started");
	AST_TRIM_DEF: assert property (wr4 && wb_sel_i[0] && !wb_dat_i[0]
		|=> ##1 osc_trim == DEFAULT_TRIM)
		else $error("default trim not applied");
	AST_RSVD_RD: assert property (taken && !wb_we_i && wb_adr_i[31:4] != 28'h0
		|=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
endmodule : fcr_checker

bind function_control_registers fcr_checker #(
	.MS_CYCLES(MS_CYCLES),
	.DEFAULT_TRIM(DEFAULT_TRIM)
) u_chk (
	.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.bus0_clk_line_filter_on(bus0_clk_line_filter_on),
	.bus0_dat_line_filter_on(bus0_dat_line_filter_on),
	.bus1_clk_line_filter_on(bus1_clk_line_filter_on),
	.bus1_dat_line_filter_on(bus1_dat_line_filter_on),
	.bus2_clk_line_filter_on(bus2_clk_line_filter_on),
	.bus2_dat_line_filter_on(bus2_dat_line_filter_on), .crystal_range(crystal_range),
	.system_key_wipe_go(system_key_wipe_go), .system_key_wipe_done(system_key_wipe_done),
	.osc_trim(osc_trim), .cal_active(cal_active));

/* tb/function_control_registers_test.sv */
// Self-checking bench for the function control register bank.
// Assumes the checker file is compiled alongside; short millisecond count.
`timescale 1ns/100ps
module function_control_registers_test;
	logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [31:0] adr = 32'h0, wdat = 32'h0, rdat;
	logic [3:0] sel = 4'h0;
	logic ack, go, done = 1'b0, tick = 1'b0, cal;
	logic [12:0] cnt = 13'h0;
	logic [8:0] trim;
	logic [2:0] rng;
	logic [5:0] filt;
	int bad_count = 0, samples_checked = 0, cycles = 0;

	function_control_registers #(.MS_CYCLES(10)) u_dut (.clk(clk), .sys_rst(sys_rst),
		.clk_en(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.bus0_clk_line_filter_on(filt[1]), .bus0_dat_line_filter_on(filt[0]),
		.bus1_clk_line_filter_on(filt[3]), .bus1_dat_line_filter_on(filt[2]),
		.bus2_clk_line_filter_on(filt[5]), .bus2_dat_line_filter_on(filt[4]),
		.crystal_range(rng), .system_key_wipe_go(go), .system_key_wipe_done(done),
		.ref_tick(tick), .osc_cycle_count(cnt), .osc_trim(trim), .cal_active(cal));

	// ----------------------------------------
	// clock, timeout and shared tasks
	// ----------------------------------------
	always #5 clk = ~clk;
	// a hung handshake must still end the run through the verdict
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			give_verdict();
		end
	end

	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			bad_count++;
		end
	endtask : check

	// one classic cycle; values read after the edge are the ones sampled at it
	task bus(input logic w, input logic [31:0] a, input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) check("bus ack", 32'h1, 32'h0);
		cyc <= 1'b0; stb <= 1'b0;
	endtask : bus

	task rd(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 4'hF, 32'h0);
		check("read data", exp, rdat);
	endtask : rd

	task pulse(input logic is_tick, input logic [12:0] c);
		@(posedge clk);
		tick <= is_tick; done <= !is_tick; cnt <= c;
		@(posedge clk);
		tick <= 1'b0; done <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : pulse

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset();
		for (int a = 0; a < 16; a += 4) rd(a, 32'h0);
		check("trim after reset", 32'h100, trim);
	endtask : t_reset

	task t_fctrl();
		bus(1'b1, 32'h0, 4'hF, 32'hFFFFFEFE);
		rd(32'h0, 32'h03F00006);
		for (int i = 6; i >= 0; i--) begin
			bus(1'b1, 32'h0, 4'h1, i);
			check("range", i, rng);
		end
		rd(32'h0, 32'h03F00000);
		for (int b = 20; b < 26; b++) begin
			bus(1'b1, 32'h0, 4'hC, 32'h1 << b);
			check("filters", 32'h1 << (b - 20), filt);
		end
	endtask : t_fctrl

	task t_wipe();
		bus(1'b1, 32'h0, 4'hF, 32'h0);
		bus(1'b1, 32'h0, 4'h2, 32'h100);
		rd(32'h0, 32'h100);
		check("wipe go", 32'h1, go);
		bus(1'b1, 32'h0, 4'h2, 32'h0);
		rd(32'h0, 32'h100);
		pulse(1'b0, 13'h0);
		rd(32'h0, 32'h0);
		check("wipe go", 32'h0, go);
	endtask : t_wipe

	task t_cal();
		int n;
		time t0;
		bus(1'b1, 32'h8, 4'hF, 32'hFFFFFFA5);
		rd(32'h8, 32'h1A5);
		bus(1'b1, 32'hC, 4'hF, 32'h3);
		bus(1'b1, 32'h4, 4'hF, 32'hFF820009);
		rd(32'h4, 32'h00020001);
		bus(1'b1, 32'h4, 4'hF, 32'h00020005);
		rd(32'h4, 32'hD2820001);
		check("trim loaded", 32'h1A5, trim);
		bus(1'b1, 32'h4, 4'hF, 32'h00020011);
		t0 = $time;
		check("cal busy", 32'h1, cal);
		pulse(1'b1, 13'h0);
		rd(32'h4, 32'hD4020019);
		n = 0;
		while (cal !== 1'b0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		check("cal end", 32'h0, cal);
		// 3 ms of 10 cycles each, plus a few cycles to start and to finish
		t0 = $time - t0;
		check("cal length ok", 32'h1, {31'h0, t0 >= 300 && t0 <= 340});
		rd(32'h4, 32'hD4020009);
		pulse(1'b1, 13'h0);
		rd(32'h4, 32'hD4020009);
		bus(1'b1, 32'h4, 4'hF, 32'h00020003);
		pulse(1'b1, 13'h0);
		rd(32'h4, 32'hD5820003);
		pulse(1'b1, 13'h7);
		rd(32'h4, 32'hD402000B);
		// count equal to a zero factor taken as one: trim must not move
		pulse(1'b1, 13'h1);
		rd(32'h4, 32'hD402000B);
		bus(1'b1, 32'h4, 4'hF, 32'h00020000);
		repeat (2) @(posedge clk);
		check("default trim", 32'h100, trim);
	endtask : t_cal

	task t_unmapped();
		bus(1'b1, 32'h10, 4'hF, 32'hFFFFFFFF);
		rd(32'h10, 32'h0);
		rd(32'h0, 32'h0);
	endtask : t_unmapped

	// request held while frozen: no ack and no write until the enable returns
	task t_freeze();
		int n;
		n = 0;
		@(posedge clk);
		ce <= 1'b0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= 1'b1;
		adr <= 32'h0;
		sel <= 4'h1;
		wdat <= 32'h5;
		repeat (3) @(posedge clk);
		check("frozen ack", 32'h0, ack);
		check("frozen range", 32'h0, rng);
		ce <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) check("bus ack", 32'h1, 32'h0);
		cyc <= 1'b0;
		stb <= 1'b0;
		check("range after freeze", 32'h5, rng);
	endtask : t_freeze

	// reset in mid-run must bring every field back to zero
	task t_rerst();
		bus(1'b1, 32'h0, 4'hF, 32'h03F00005);
		bus(1'b1, 32'h8, 4'hF, 32'h1FF);
		bus(1'b1, 32'h4, 4'hF, 32'h000FF003);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		check("filters in reset", 32'h0, filt);
		t_reset();
	endtask : t_rerst

	task give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_fctrl();
		t_wipe();
		t_cal();
		t_unmapped();
		t_freeze();
		t_rerst();
		give_verdict();
	end
endmodule : function_control_registers_test
